// file: core/shrp_host.sv
/*
 * Host-side read controller for an asynchronous SRAM-like read port.
 * Software orders single or burst reads through a small register port;
 * the controller drives the select, strobe, address and FIFO-select pins,
 * samples the data pins through a two-stage synchroniser and keeps the
 * captured words for software. Assumes the device answers within the
 * documented access times and that the data pins are driven only by it.
 */
// Contract
// - Cycle runs while select and strobe both low
// - Raise select/strobe between single reads, least time
// - Burst at most 8 words or 16 halfwords
// - Raise select/strobe between bursts, least time
// - At least 165 ns per cycle or step
// - Wait 165 ns before FIFO information reads
// - Wait 330 ns between dropped-frame counter reads
// - Wait 330 ns after datapath control, status FIFOs
// - Waits may be met by time or dummies
`timescale 1ns/10ps
module shrp_host
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic chip_sel_low,
    output logic read_strobe_low,
    output logic [7:1] dev_addr,
    output logic fifo_sel,
    input wire logic [31:0] dev_data
);

    shrp_pkg::shrp_state_t state_ff; // Sequencer state
    shrp_pkg::shrp_state_t nxt_state;
    logic [3:0] cnt_ff; // Cycles left in the current phase
    logic [3:0] nxt_cnt;
    logic [7:0] addr_ff; // Device byte address being read
    logic [7:0] nxt_addr;
    logic fifo_ff; // FIFO select for the order
    logic nxt_fifo;
    logic w16_ff; // Sixteen-bit order
    logic nxt_w16;
    logic [4:0] last_ff; // Index of the last beat
    logic [4:0] nxt_last;
    logic [4:0] beat_ff; // Current beat index
    logic [4:0] nxt_beat;
    logic [4:0] got_ff; // Beats captured so far
    logic [4:0] nxt_got;
    logic cs_ff; // Select pin, low active
    logic nxt_cs;
    logic rd_ff; // Strobe pin, low active
    logic nxt_rd;
    logic [31:0] rdata_ff; // Software read data
    logic [31:0] nxt_rdata;
    logic [31:0] sync1_ff; // First synchroniser stage
    logic [31:0] sync2_ff; // Second synchroniser stage
    logic [31:0] buf_ff [16]; // Captured words
    logic [31:0] nxt_buf [16];
    logic hold; // A read-after-read wait that protects the ordered read is running
    logic done; // One device read just finished
    logic ctrl_wr; // Software writes the control register
    logic [4:0] req_len; // Requested beats minus one
    logic [4:0] max_len; // Width limit minus one

    assign ctrl_wr = sw_wr && (sw_addr == shrp_pkg::REG_CTRL);
    assign req_len = {1'b0, sw_wdata[shrp_pkg::CTRL_LEN_LSB +: 4]};
    assign max_len = (sw_wdata[shrp_pkg::CTRL_W16_BIT] ? shrp_pkg::BURST_MAX_16 : shrp_pkg::BURST_MAX_32)
        - 5'h01;
    assign done = (state_ff == shrp_pkg::SHRP_ACTIVE) && (cnt_ff == 4'h1);

    // Wait timers between dependent reads
    shrp_guard u_guard
    (
        .clk(clk),
        .srst(srst),
        .done(done),
        .done_addr(addr_ff),
        .done_fifo(fifo_ff),
        .chk_addr(addr_ff),
        .chk_fifo(fifo_ff),
        .hold(hold)
    );

    // Pin sequencer next state
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_fifo = fifo_ff;
        nxt_w16 = w16_ff;
        nxt_last = last_ff;
        nxt_beat = beat_ff;
        nxt_got = got_ff;
        nxt_cs = 1'b1;
        nxt_rd = 1'b1;
        unique case (state_ff)
            shrp_pkg::SHRP_IDLE:
            begin
                // Orders are only taken when idle
                if (ctrl_wr)
                begin
                    nxt_addr = sw_wdata[shrp_pkg::CTRL_ADDR_LSB +: 8];
                    nxt_fifo = sw_wdata[shrp_pkg::CTRL_FIFO_BIT];
                    nxt_w16 = sw_wdata[shrp_pkg::CTRL_W16_BIT];
                    nxt_last = (req_len > max_len) ? max_len : req_len;
                    nxt_beat = 5'h00;
                    nxt_got = 5'h00;
                    nxt_state = shrp_pkg::SHRP_SETUP;
                end
            end
            shrp_pkg::SHRP_SETUP:
            begin
                // Address is out a cycle ahead; wait out any guard protecting this read
                if (!hold)
                begin
                    nxt_cs = 1'b0;
                    nxt_rd = 1'b0;
                    nxt_cnt = shrp_pkg::CYC_STROBE;
                    nxt_state = shrp_pkg::SHRP_ACTIVE;
                end
            end
            shrp_pkg::SHRP_ACTIVE:
            begin
                nxt_cs = 1'b0;
                nxt_rd = 1'b0;
                nxt_cnt = cnt_ff - 4'h1;
                if (done)
                begin
                    nxt_got = got_ff + 5'h01;
                    if (beat_ff == last_ff)
                    begin
                        // End the cycle by raising both pins
                        nxt_cs = 1'b1;
                        nxt_rd = 1'b1;
                        nxt_cnt = shrp_pkg::CYC_CSH;
                        nxt_state = shrp_pkg::SHRP_GAP;
                    end
                    else
                    begin
                        // Next burst step: only the address moves
                        nxt_beat = beat_ff + 5'h01;
                        nxt_addr = addr_ff + (w16_ff ? 8'h02 : 8'h04);
                        nxt_cnt = shrp_pkg::CYC_STROBE;
                    end
                end
            end
            shrp_pkg::SHRP_GAP:
            begin
                // Pins stay high for the deassertion time
                nxt_cnt = cnt_ff - 4'h1;
                if (cnt_ff == 4'h1)
                begin
                    nxt_state = shrp_pkg::SHRP_IDLE;
                end
            end
        endcase
    end

    // Capture buffer next values
    for (genvar i = 0; i < 16; i++)
    begin : gen_buf
        always_comb
        begin
            nxt_buf[i] = buf_ff[i];
            if (done && beat_ff == 5'(i))
            begin
                // Upper half is undriven in sixteen-bit mode
                nxt_buf[i] = w16_ff ? {16'h0000, sync2_ff[15:0]} : sync2_ff;
            end
        end
    end

    // Software read data next value
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (sw_rd)
        begin
            if (sw_addr == shrp_pkg::REG_STATUS)
            begin
                nxt_rdata[shrp_pkg::STS_BUSY_BIT] = (state_ff != shrp_pkg::SHRP_IDLE);
                nxt_rdata[shrp_pkg::STS_HOLD_BIT] = (state_ff == shrp_pkg::SHRP_SETUP) && hold;
                nxt_rdata[shrp_pkg::STS_CNT_LSB +: 5] = got_ff;
            end
            else if (sw_addr[7:6] == shrp_pkg::REG_DATA_BASE[7:6] && sw_addr[1:0] == 2'b00)
            begin
                nxt_rdata = buf_ff[sw_addr[5:2]];
            end
        end
    end

    // Data pin synchroniser
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_ff <= 32'h0000_0000;
            sync2_ff <= 32'h0000_0000;
        end
        else
        begin
            sync1_ff <= dev_data;
            sync2_ff <= sync1_ff;
        end
    end

    // Sequencer, buffer and read data registers
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_ff <= shrp_pkg::SHRP_IDLE;
            cnt_ff <= 4'h0;
            addr_ff <= 8'h00;
            fifo_ff <= 1'b0;
            w16_ff <= 1'b0;
            last_ff <= 5'h00;
            beat_ff <= 5'h00;
            got_ff <= 5'h00;
            cs_ff <= 1'b1;
            rd_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            for (int k = 0; k < 16; k++)
            begin
                buf_ff[k] <= 32'h0000_0000;
            end
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            fifo_ff <= nxt_fifo;
            w16_ff <= nxt_w16;
            last_ff <= nxt_last;
            beat_ff <= nxt_beat;
            got_ff <= nxt_got;
            cs_ff <= nxt_cs;
            rd_ff <= nxt_rd;
            rdata_ff <= nxt_rdata;
            for (int k = 0; k < 16; k++)
            begin
                buf_ff[k] <= nxt_buf[k];
            end
        end
    end

    // Pin and port outputs
    assign chip_sel_low = cs_ff;
    assign read_strobe_low = rd_ff;
    assign dev_addr = addr_ff[7:1];
    assign fifo_sel = fifo_ff;
    assign sw_rdata = rdata_ff;

endmodule

// file: core/shrp_pkg.sv
/*
 * Shared constants of the host read controller: its own register map,
 * field positions, pin timing counts and the device resource addresses.
 * Assumes a 25 MHz controller clock; every cycle count is derived from it.
 */
package shrp_pkg;

    // Controller clock period
    localparam int CLK_NS = 40;

    // Pin timing, figures in ns
    localparam int T_CYCLE_NS = 165;
    localparam int T_CSH_NS = 13;
    localparam int T_WAIT_SHORT_NS = 165;
    localparam int T_WAIT_LONG_NS = 330;

    // Least times round up to whole cycles
    localparam logic [3:0] CYC_STROBE = 4'((T_CYCLE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] CYC_CSH = 4'((T_CSH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] CYC_WAIT_SHORT = 4'((T_WAIT_SHORT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] CYC_WAIT_LONG = 4'((T_WAIT_LONG_NS + CLK_NS - 1) / CLK_NS);

    // Burst limits in beats
    localparam logic [4:0] BURST_MAX_32 = 5'h08;
    localparam logic [4:0] BURST_MAX_16 = 5'h10;

    // Software register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA_BASE = 8'h40;

    // Control register fields
    localparam int CTRL_ADDR_LSB = 0;
    localparam int CTRL_FIFO_BIT = 8;
    localparam int CTRL_W16_BIT = 9;
    localparam int CTRL_LEN_LSB = 12;

    // Status register fields
    localparam int STS_BUSY_BIT = 0;
    localparam int STS_HOLD_BIT = 1;
    localparam int STS_CNT_LSB = 8;

    // Device resource byte addresses
    localparam logic [7:0] DEV_RX_DATA = 8'h00;
    localparam logic [7:0] DEV_RX_STS = 8'h40;
    localparam logic [7:0] DEV_TX_STS = 8'h48;
    localparam logic [7:0] DEV_RX_INF = 8'h7c;
    localparam logic [7:0] DEV_TX_INF = 8'h80;
    localparam logic [7:0] DEV_RX_DROP = 8'ha0;
    localparam logic [7:0] DEV_RX_DP = 8'ha8;

    // Number of read-after-read guards
    localparam int NUM_GUARD = 4;

    // Pin sequencer states
    typedef enum logic [1:0] {
        SHRP_IDLE = 2'b00,
        SHRP_SETUP = 2'b01,
        SHRP_ACTIVE = 2'b10,
        SHRP_GAP = 2'b11
    } shrp_state_t;

endpackage

// file: core/shrp_guard.sv
/*
 * Read-after-read guard timers. Each finished device read may arm a timer;
 * while a timer runs, reads of the resources it protects are held off.
 * Assumes done pulses come from the pin sequencer on the same clock.
 */
`timescale 1ns/10ps
module shrp_guard
(
    input wire logic clk,
    input wire logic srst,
    input wire logic done,
    input wire logic [7:0] done_addr,
    input wire logic done_fifo,
    input wire logic [7:0] chk_addr,
    input wire logic chk_fifo,
    output logic hold
);

    // Timer reload values per guard
    localparam logic [3:0] LOAD [shrp_pkg::NUM_GUARD] = '{
        shrp_pkg::CYC_WAIT_SHORT, shrp_pkg::CYC_WAIT_SHORT,
        shrp_pkg::CYC_WAIT_LONG, shrp_pkg::CYC_WAIT_LONG};

    logic [shrp_pkg::NUM_GUARD-1:0] trig; // Which guards a finished read arms
    logic [shrp_pkg::NUM_GUARD-1:0] tgt; // Which guards protect the next read
    logic [shrp_pkg::NUM_GUARD-1:0] running; // Guards still counting
    logic d_rxd; // Finished read hit the receive data FIFO
    logic c_reg; // Next read is a plain register read

    // Decode trigger and target resources
    always_comb
    begin
        d_rxd = done_fifo || (done_addr == shrp_pkg::DEV_RX_DATA);
        c_reg = !chk_fifo;
        trig[0] = done && (d_rxd || (!done_fifo && done_addr == shrp_pkg::DEV_RX_STS));
        trig[1] = done && !done_fifo && (done_addr == shrp_pkg::DEV_TX_STS);
        trig[2] = done && !done_fifo && (done_addr == shrp_pkg::DEV_RX_DROP);
        trig[3] = done && !done_fifo && (done_addr == shrp_pkg::DEV_RX_DP);
        tgt[0] = c_reg && (chk_addr == shrp_pkg::DEV_RX_INF);
        tgt[1] = c_reg && (chk_addr == shrp_pkg::DEV_TX_INF);
        tgt[2] = c_reg && (chk_addr == shrp_pkg::DEV_RX_DROP);
        tgt[3] = c_reg && (chk_addr == shrp_pkg::DEV_RX_STS || chk_addr == shrp_pkg::DEV_TX_STS);
    end

    // One down-counter per guard
    for (genvar g = 0; g < shrp_pkg::NUM_GUARD; g++)
    begin : gen_guard
        logic [3:0] cnt_ff; // Cycles left in this wait
        logic [3:0] nxt_cnt; // Next count

        // Reload on trigger, else count down to zero
        always_comb
        begin
            if (trig[g])
            begin
                nxt_cnt = LOAD[g];
            end
            else if (cnt_ff != 4'h0)
            begin
                nxt_cnt = cnt_ff - 4'h1;
            end
            else
            begin
                nxt_cnt = cnt_ff;
            end
        end

        // Register the count
        always_ff @(posedge clk)
        begin
            if (srst)
            begin
                cnt_ff <= 4'h0;
            end
            else
            begin
                cnt_ff <= nxt_cnt;
            end
        end

        assign running[g] = (cnt_ff != 4'h0);
    end

    // Hold off while any protecting guard runs
    assign hold = |(running & tgt);

endmodule

// file: verification/shrp_host_assertions.sv
/*
 * Pin timing checker of the host read controller.
 * Assumes it is bound to shrp_host and sees only its ports.
 */
`timescale 1ns/10ps
module shrp_host_checker
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    input wire logic [31:0] sw_rdata,
    input wire logic chip_sel_low,
    input wire logic read_strobe_low,
    input wire logic [7:1] dev_addr,
    input wire logic fifo_sel,
    input wire logic [31:0] dev_data
);
    // High cycles before an access, saturating
    logic [3:0] gap_ff;
    logic [3:0] nxt_gap;
    // Length of the current low run
    logic [6:0] run_ff;
    logic [6:0] nxt_run;
    // Address and select of the last access
    logic [7:1] last_ff;
    logic [7:1] nxt_last;
    logic lastf_ff;
    logic nxt_lastf;

    // Next values of the helper counters
    always_comb
    begin
        nxt_gap = !chip_sel_low ? 4'h0 : (gap_ff == 4'hf ? gap_ff : gap_ff + 4'h1);
        nxt_run = chip_sel_low ? 7'h0 : run_ff + 7'h1;
        nxt_last = chip_sel_low ? last_ff : dev_addr;
        nxt_lastf = chip_sel_low ? lastf_ff : fifo_sel;
    end

    // Registers of the helper counters
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            gap_ff <= 4'hf;
            run_ff <= 7'h0;
            last_ff <= 7'h0;
            lastf_ff <= 1'b0;
        end
        else
        begin
            gap_ff <= nxt_gap;
            run_ff <= nxt_run;
            last_ff <= nxt_last;
            lastf_ff <= nxt_lastf;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_pins_together: assert property (chip_sel_low == read_strobe_low)
        else $error("select and strobe differ");
    a_low_min_time: assert property ($fell(chip_sel_low) |-> !chip_sel_low [*5])
        else $error("access shorter than cycle time");
    a_gap_high: assert property ($rose(chip_sel_low) |=> chip_sel_low)
        else $error("deassertion too short");
    a_addr_setup: assert property ($fell(chip_sel_low) |-> $stable(dev_addr) && $stable(fifo_sel))
        else $error("address moved at access start");
    a_beat_hold: assert property ($changed(dev_addr) && !chip_sel_low && $past(!chip_sel_low)
        |=> ($stable(dev_addr) && !chip_sel_low) [*4])
        else $error("burst step too short");
    a_fifo_steady: assert property (!chip_sel_low && $past(!chip_sel_low) |-> $stable(fifo_sel))
        else $error("fifo select moved in access");
    a_burst_limit: assert property (run_ff <= 7'h50)
        else $error("burst too long");
    a_drop_wait: assert property ($fell(chip_sel_low) && !fifo_sel && !lastf_ff
        && dev_addr == shrp_pkg::DEV_RX_DROP[7:1] && last_ff == shrp_pkg::DEV_RX_DROP[7:1] |-> gap_ff >= 4'h9)
        else $error("drop counter reread too soon");
    a_info_wait: assert property ($fell(chip_sel_low) && !fifo_sel && dev_addr == shrp_pkg::DEV_RX_INF[7:1]
        && (lastf_ff || last_ff == shrp_pkg::DEV_RX_DATA[7:1] || last_ff == shrp_pkg::DEV_RX_STS[7:1])
        |-> gap_ff >= 4'h5)
        else $error("fifo info read too soon");
    a_dp_wait: assert property ($fell(chip_sel_low) && !fifo_sel && !lastf_ff
        && (dev_addr == shrp_pkg::DEV_RX_STS[7:1] || dev_addr == shrp_pkg::DEV_TX_STS[7:1])
        && last_ff == shrp_pkg::DEV_RX_DP[7:1] |-> gap_ff >= 4'h9)
        else $error("status read too soon after datapath control");

    c_fifo_read: cover property ($fell(chip_sel_low) && fifo_sel);
    c_long_burst: cover property (run_ff == 7'h4f);
    c_drop_pair: cover property ($fell(chip_sel_low) && last_ff == shrp_pkg::DEV_RX_DROP[7:1]);
endmodule

bind shrp_host shrp_host_checker u_chk (.clk(clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .chip_sel_low(chip_sel_low),
    .read_strobe_low(read_strobe_low), .dev_addr(dev_addr), .fifo_sel(fifo_sel), .dev_data(dev_data));

// file: verification/shrp_dev_model.sv
/*
 * Behavioural model of the device read port.
 * Assumes pins move just after rising clk edges; bus16 gives the strap width.
 */
`timescale 1ns/10ps
module shrp_dev_model
(
    input wire logic clk,
    input wire logic chip_sel_low,
    input wire logic read_strobe_low,
    input wire logic [7:1] dev_addr,
    input wire logic fifo_sel,
    input wire logic bus16,
    output logic [31:0] dev_data
);
    // Access seen at the last edge and its address
    logic sel_q;
    logic [7:1] addr_q;
    logic [7:0] b;

    initial dev_data = 32'h0;
    assign b = {dev_addr, 1'b0};

    // Answer an access; released lines toggle so no stale value survives
    always @(posedge clk)
    begin
        sel_q <= !chip_sel_low && !read_strobe_low;
        addr_q <= dev_addr;
        if (!chip_sel_low && !read_strobe_low)
        begin
            // Value taken once at access start or burst step
            if (!sel_q || addr_q != dev_addr)
            begin
                dev_data <= fifo_sel ? {24'h5aa5c3, 5'h0, dev_addr[2:1], 1'b0} : {b, ~b, b ^ 8'h5a, 8'h3c};
            end
        end
        else
        begin
            // Released lines show the inverse of the last value
            dev_data <= ~dev_data;
        end
        // Upper lines undriven in narrow mode
        if (bus16)
            dev_data[31:16] <= ~dev_data[31:16];
    end
endmodule

// file: verification/test_shrp_host.sv
/*
 * Self-checking testbench of the host read controller.
 * Assumes the device model and the bound checker beside it.
 */
`timescale 1ns/10ps
module test_shrp_host;
    logic clk, srst, sw_wr, sw_rd, chip_sel_low, read_strobe_low, fifo_sel, bus16;
    logic [7:0] sw_addr;
    logic [31:0] sw_wdata, sw_rdata, dev_data, d;
    logic [7:1] dev_addr;
    int err_count, checks;

    shrp_host dut (.clk(clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata), .chip_sel_low(chip_sel_low), .read_strobe_low(read_strobe_low),
        .dev_addr(dev_addr), .fifo_sel(fifo_sel), .dev_data(dev_data));
    shrp_dev_model dev (.clk(clk), .chip_sel_low(chip_sel_low), .read_strobe_low(read_strobe_low),
        .dev_addr(dev_addr), .fifo_sel(fifo_sel), .bus16(bus16), .dev_data(dev_data));

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Count one comparison and report a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Print the verdict and end the run
    task automatic complete_run;
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One-cycle write strobe beside address and data
    task automatic sw_write(input logic [7:0] a, input logic [31:0] v);
        sw_addr <= a;
        sw_wdata <= v;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
        @(posedge clk);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic sw_read(input logic [7:0] a, output logic [31:0] v);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(posedge clk);
        // Taken at the edge that closes the answer cycle
        v = sw_rdata;
    endtask

    // Order one read, try a refused order, wait and compare captured words
    task automatic do_read(input logic [7:0] a, input logic f, input logic w, input logic [3:0] len,
        input int beats, input logic held);
        logic [31:0] s, v, e;
        logic [7:0] b;
        int n;
        bus16 <= w;
        sw_write(shrp_pkg::REG_CTRL, {16'h0, len, 2'h0, w, f, a});
        if (held)
        begin
            sw_read(shrp_pkg::REG_STATUS, s);
            check(32'(s[1]), 32'h1);
        end
        sw_write(shrp_pkg::REG_CTRL, 32'h0000_00e0);
        n = 0;
        s = 32'h1;
        while (s[0] !== 1'b0 && n < 300)
        begin
            sw_read(shrp_pkg::REG_STATUS, s);
            n++;
        end
        check(32'(s[12:8]), 32'(beats));
        for (int i = 0; i < beats; i++)
        begin
            b = a + 8'(i * (w ? 2 : 4));
            e = f ? {24'h5aa5c3, 5'h0, b[2:1], 1'b0} : {b, ~b, b ^ 8'h5a, 8'h3c};
            if (w)
                e[31:16] = 16'h0;
            sw_read(8'(shrp_pkg::REG_DATA_BASE + 4 * i), v);
            check(v, e);
        end
    endtask

    task automatic t_reset;
        check(32'({chip_sel_low, read_strobe_low, fifo_sel, dev_addr}), 32'h300);
        sw_read(8'h08, d);
        check(d, 32'h0);
    endtask

    task automatic t_single;
        do_read(8'h10, 1'b0, 1'b0, 4'h0, 1, 1'b0);
        do_read(8'h12, 1'b0, 1'b1, 4'h0, 1, 1'b0);
    endtask

    task automatic t_burst;
        do_read(8'h20, 1'b0, 1'b0, 4'hf, 8, 1'b0);
        do_read(8'h10, 1'b0, 1'b1, 4'hf, 16, 1'b0);
    endtask

    task automatic t_fifo;
        do_read(8'hf6, 1'b1, 1'b0, 4'h0, 1, 1'b0);
        do_read(8'h3a, 1'b1, 1'b1, 4'h0, 1, 1'b0);
        do_read(shrp_pkg::DEV_RX_INF, 1'b0, 1'b0, 4'h0, 1, 1'b0);
    endtask

    task automatic t_guard;
        do_read(shrp_pkg::DEV_RX_STS, 1'b0, 1'b0, 4'h0, 1, 1'b0);
        do_read(shrp_pkg::DEV_RX_INF, 1'b0, 1'b0, 4'h0, 1, 1'b0);
        do_read(shrp_pkg::DEV_TX_STS, 1'b0, 1'b0, 4'h0, 1, 1'b0);
        do_read(shrp_pkg::DEV_TX_INF, 1'b0, 1'b0, 4'h0, 1, 1'b0);
        do_read(shrp_pkg::DEV_RX_DROP, 1'b0, 1'b0, 4'h0, 1, 1'b0);
        do_read(shrp_pkg::DEV_RX_DROP, 1'b0, 1'b0, 4'h0, 1, 1'b1);
        do_read(shrp_pkg::DEV_RX_DP, 1'b0, 1'b0, 4'h0, 1, 1'b0);
        do_read(shrp_pkg::DEV_TX_STS, 1'b0, 1'b0, 4'h0, 1, 1'b1);
    endtask

    // Main sequence
    initial
    begin
        srst = 1'b1;
        sw_addr = 8'h0;
        sw_wdata = 32'h0;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        bus16 = 1'b0;
        err_count = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_single;
        t_burst;
        t_fifo;
        t_guard;
        complete_run;
    end

    // Cut a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run;
    end
endmodule
